// ---- rtl/ppcgw_top.sv ----
// Pin control registers lower half with global multi-pin writes over APB.
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`include "ppcgw_defs.svh"
module ppcgw_top
  import ppcgw_pkg::*;
#(
  parameter logic [31:0] CAP_DSE = 32'hFFFFFFFF,
  parameter logic [31:0] CAP_PFE = 32'hFFFFFFFF,
  parameter logic [31:0] CAP_SRE = 32'hFFFFFFFF,
  parameter logic [31:0] CAP_PE  = 32'hFFFFFFFF,
  parameter logic [31:0] CAP_PS  = 32'hFFFFFFFF,
  parameter logic [31:0] FIX_PS  = 32'h00000000
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic [31:0] outBufReq,
  output logic [31:0]      highDrive,
  output logic [31:0]      slowSlew,
  output logic [31:0]      filterOn,
  output logic [31:0]      pullUpOn,
  output logic [31:0]      pullDownOn,
  output logic [31:0]      inBufOn,
  output logic [31:0]      outBufOn
);
  logic        rstMeta;
  logic        rstSync;
  ppcgw_half_t pcr      [`PPCGW_NPINS];
  ppcgw_half_t next_pcr [`PPCGW_NPINS];
  logic        next_pready;
  logic        next_pslverr;
  ppcgw_word_t next_prdata;
  logic [31:0] next_highDrive;
  logic [31:0] next_slowSlew;
  logic [31:0] next_filterOn;
  logic [31:0] next_pullUpOn;
  logic [31:0] next_pullDownOn;
  logic [31:0] next_inBufOn;
  logic [31:0] next_outBufOn;
  logic        setupWr;
  logic        setupRd;
  logic        isGlow;
  logic        isGhigh;
  logic        isPcr;
  logic [4:0]  pcrIdx;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  assign setupWr = psel && !penable && pwrite;
  assign setupRd = psel && !penable && !pwrite;
  assign isGlow  = (paddr == `PPCGW_OFF_GLOW);
  assign isGhigh = (paddr == `PPCGW_OFF_GHIGH);
  assign isPcr   = (paddr < `PPCGW_OFF_GLOW) && (paddr[1:0] == 2'h0);
  assign pcrIdx  = paddr[6:2];

  // Writable mask for one pin: fixed-function bits stay read-only.
  function automatic ppcgw_half_t pinMask(input int unsigned n);
    ppcgw_half_t m;
    m = `PPCGW_WMASK;
    m[`PPCGW_BIT_DSE] = CAP_DSE[n];
    m[`PPCGW_BIT_PFE] = CAP_PFE[n];
    m[`PPCGW_BIT_SRE] = CAP_SRE[n];
    m[`PPCGW_BIT_PE]  = CAP_PE[n];
    m[`PPCGW_BIT_PS]  = CAP_PS[n] && !FIX_PS[n];
    return m;
  endfunction : pinMask

  // Register writes take effect in the setup cycle; the access phase then completes.
  always_comb begin
    for (int i = 0; i < `PPCGW_NPINS; i++) begin
      ppcgw_half_t m;
      logic        hit;
      logic [15:0] val;
      m   = pinMask(i);
      hit = 1'b0;
      val = pcr[i];
      next_pcr[i] = pcr[i];
      if (setupWr && isPcr && pcrIdx == 5'(i)) begin
        hit = 1'b1;
        if (pstrb[0]) val[7:0]  = pwdata[7:0];
        if (pstrb[1]) val[15:8] = pwdata[15:8];
      end
      if (setupWr && pstrb == `PPCGW_STRB_ALL) begin
        if (i < 16 && isGlow && pwdata[16 + (i % 16)]) begin
          hit = 1'b1;
          val = pwdata[15:0];
        end
        if (i >= 16 && isGhigh && pwdata[i]) begin
          hit = 1'b1;
          val = pwdata[15:0];
        end
      end
      if (hit && !pcr[i][`PPCGW_BIT_LK]) begin
        next_pcr[i] = (val & m) | (pcr[i] & ~m);
      end
    end
  end

  always_comb begin
    next_pready  = psel && !penable;
    next_pslverr = psel && !penable && !(isPcr || isGlow || isGhigh);
    next_prdata  = '0;
    if (setupRd && isPcr) begin
      next_prdata = {16'h0000, pcr[pcrIdx]};
    end else if (setupRd) begin
      next_prdata = '0;
    end
  end

  // Pad controls follow the register settings and the mux field.
  always_comb begin
    for (int i = 0; i < `PPCGW_NPINS; i++) begin
      logic dig;
      logic pullAct;
      dig = pcr[i][`PPCGW_MUX_HI:`PPCGW_MUX_LO] != `PPCGW_MUX_OFF;
      pullAct = dig && pcr[i][`PPCGW_BIT_PE] && !(dig && outBufReq[i]);
      next_outBufOn[i]   = dig && outBufReq[i];
      next_inBufOn[i]    = dig;
      next_highDrive[i]  = dig && outBufReq[i] && pcr[i][`PPCGW_BIT_DSE];
      next_slowSlew[i]   = dig && outBufReq[i] && pcr[i][`PPCGW_BIT_SRE];
      next_filterOn[i]   = dig && pcr[i][`PPCGW_BIT_PFE];
      next_pullUpOn[i]   = pullAct && pcr[i][`PPCGW_BIT_PS];
      next_pullDownOn[i] = pullAct && !pcr[i][`PPCGW_BIT_PS];
    end
  end

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      for (int i = 0; i < `PPCGW_NPINS; i++) begin
        pcr[i] <= `PPCGW_RESET_VAL;
      end
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= '0;
      highDrive  <= '0;
      slowSlew   <= '0;
      filterOn   <= '0;
      pullUpOn   <= '0;
      pullDownOn <= '0;
      inBufOn    <= '0;
      outBufOn   <= '0;
    end else begin
      for (int i = 0; i < `PPCGW_NPINS; i++) begin
        pcr[i] <= next_pcr[i];
      end
      pready     <= next_pready;
      pslverr    <= next_pslverr;
      prdata     <= next_prdata;
      highDrive  <= next_highDrive;
      slowSlew   <= next_slowSlew;
      filterOn   <= next_filterOn;
      pullUpOn   <= next_pullUpOn;
      pullDownOn <= next_pullDownOn;
      inBufOn    <= next_inBufOn;
      outBufOn   <= next_outBufOn;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstSync);

  sequence glowWrite(int n);
    setupWr && isGlow && pstrb == `PPCGW_STRB_ALL && pwdata[16 + n] && !pcr[n][`PPCGW_BIT_LK];
  endsequence

  chk_glow_load: assert property (glowWrite(0) |=> pcr[0] == (($past(pwdata[15:0]) & pinMask(0)) | ($past(pcr[0]) & ~pinMask(0)))) else $error("low global write did not load pin 0");
  chk_ghigh_load: assert property (setupWr && isGhigh && pstrb == `PPCGW_STRB_ALL && pwdata[31] && !pcr[31][`PPCGW_BIT_LK] |=> pcr[31][`PPCGW_BIT_DSE] == ($past(pwdata[`PPCGW_BIT_DSE]) || !CAP_DSE[31] && $past(pcr[31][`PPCGW_BIT_DSE]))) else $error("high global write did not load pin 31");
  chk_mask_keep: assert property (setupWr && isGlow && !pwdata[17] |=> $stable(pcr[1])) else $error("unselected pin changed");
  chk_lock_hold: assert property (pcr[2][`PPCGW_BIT_LK] |=> $stable(pcr[2])) else $error("locked pin changed");
  chk_resv_zero: assert property (pcr[3][5] == 1'b0 && pcr[3][3] == 1'b0) else $error("reserved bit set");
  chk_glob_read: assert property (setupRd && (isGlow || isGhigh) |=> pready && prdata == '0) else $error("global read not zero");
  chk_pull_out: assert property (outBufOn[4] |-> !pullUpOn[4] && !pullDownOn[4]) else $error("pull active with output");
  chk_analog_off: assert property ($past(pcr[5][`PPCGW_MUX_HI:`PPCGW_MUX_LO]) == `PPCGW_MUX_OFF |-> !inBufOn[5] && !filterOn[5] && !pullUpOn[5]) else $error("analog pin active");
  chk_part_write: assert property (setupWr && isGlow && pstrb != `PPCGW_STRB_ALL |=> $stable(pcr[6])) else $error("partial global write acted");
  chk_drive_gate: assert property (highDrive[5] |-> outBufOn[5]) else $error("high drive without output");
  chk_slew_gate: assert property (slowSlew[20] |-> outBufOn[20]) else $error("slow slew without output");
endmodule : ppcgw_top

// ---- rtl/ppcgw_defs.svh ----
// Constants for the pin pad configuration block.
`ifndef PPCGW_DEFS_SVH
`define PPCGW_DEFS_SVH
`define PPCGW_NPINS        32
`define PPCGW_ADDR_W       8
`define PPCGW_PCR_STRIDE   8'h04
`define PPCGW_OFF_GLOW     8'h80
`define PPCGW_OFF_GHIGH    8'h84
`define PPCGW_BIT_PS       0
`define PPCGW_BIT_PE       1
`define PPCGW_BIT_SRE      2
`define PPCGW_BIT_PFE      4
`define PPCGW_BIT_DSE      6
`define PPCGW_BIT_LK       15
`define PPCGW_MUX_HI       10
`define PPCGW_MUX_LO       8
`define PPCGW_MUX_OFF      3'h0
`define PPCGW_WMASK        16'h8757
`define PPCGW_RESET_VAL    16'h0000
`define PPCGW_STRB_ALL     4'hF
`endif

// ---- rtl/ppcgw_pkg.sv ----
// Types shared by the pin pad configuration block.
package ppcgw_pkg;
  typedef logic [15:0] ppcgw_half_t;
  typedef logic [31:0] ppcgw_word_t;
endpackage : ppcgw_pkg

// ---- verification/test_pin_pad_config_global_write.sv ----
// Self-checking bench for the pin pad configuration block.
`timescale 1ns/10ps
module test_pin_pad_config_global_write;
  import ppcgw_pkg::*;
  typedef struct packed {
    logic [4:0]  pin;
    logic [15:0] wv;
    logic        obr;
    logic [15:0] rd;
    logic [6:0]  pads;
    logic [6:0]  pmask;
  } ppcgw_row_s;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] outBufReq = 32'h0;
  logic        pready, pslverr;
  logic [31:0] prdata, highDrive, slowSlew, filterOn, pullUpOn, pullDownOn, inBufOn, outBufOn;
  int          failures = 0;
  int          samplesChecked = 0;
  logic [6:0]  padSeen;
  // Pad order is drive, slew, filter, pull up, pull down, input buffer, output buffer.
  ppcgw_row_s  rows [5] = '{
    '{5'd0,  16'h0157, 1'b0, 16'h0157, 7'h1A, 7'h7F},
    '{5'd5,  16'h0243, 1'b1, 16'h0243, 7'h43, 7'h7F},
    '{5'd31, 16'h003F, 1'b0, 16'h0017, 7'h00, 7'h7F},
    '{5'd9,  16'h0702, 1'b0, 16'h0702, 7'h06, 7'h7F},
    '{5'd20, 16'h0464, 1'b1, 16'h0444, 7'h63, 7'h7F}};
  ppcgw_top dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .outBufReq(outBufReq), .highDrive(highDrive), .slowSlew(slowSlew),
    .filterOn(filterOn), .pullUpOn(pullUpOn), .pullDownOn(pullDownOn), .inBufOn(inBufOn),
    .outBufOn(outBufOn));
  always #2 clk = ~clk;
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic completeRun;
    $display("checks %0d mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : completeRun
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, s, r, e);
  endtask : wr
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, 4'h0, r, e);
    check(nm, r, exp);
  endtask : rdchk
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    completeRun();
  end
  initial begin
    logic [31:0] r;
    logic        e;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("inBufOn in reset", inBufOn, 32'h0);
    @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    rdchk("pin3 reset", 8'h0C, 32'h0);
    foreach (rows[i]) begin
      outBufReq <= 32'(rows[i].obr) << rows[i].pin;
      wr({rows[i].pin, 2'b00}, {16'hFFFF, rows[i].wv}, 4'hF);
      rdchk("pin readback", {rows[i].pin, 2'b00}, {16'h0, rows[i].rd});
      repeat (2) @(posedge clk);
      @(negedge clk);
      padSeen = {highDrive[rows[i].pin], slowSlew[rows[i].pin], filterOn[rows[i].pin],
                 pullUpOn[rows[i].pin], pullDownOn[rows[i].pin], inBufOn[rows[i].pin],
                 outBufOn[rows[i].pin]};
      check("pads", 32'(padSeen & rows[i].pmask), 32'(rows[i].pads));
    end
    wr(8'h04, 32'h0000_0101, 4'hF);
    wr(8'h80, 32'h0005_0126, 4'hF);
    rdchk("glow pin0", 8'h00, 32'h0106);
    rdchk("glow pin2", 8'h08, 32'h0106);
    rdchk("glow pin1", 8'h04, 32'h0101);
    rdchk("glow read", 8'h80, 32'h0);
    wr(8'h84, 32'h8000_0302, 4'hF);
    rdchk("ghigh pin31", 8'h7C, 32'h0302);
    rdchk("ghigh pin20", 8'h50, 32'h0444);
    rdchk("ghigh read", 8'h84, 32'h0);
    wr(8'h84, 32'hFFFF_0001, 4'h3);
    rdchk("narrow global", 8'h7C, 32'h0302);
    apb(1'b0, 8'h88, 32'h0, 4'h0, r, e);
    check("unmapped err", 32'(e), 32'h1);
    wr(8'h08, 32'h0000_8001, 4'hF);
    wr(8'h08, 32'h0000_0002, 4'hF);
    wr(8'h80, 32'h0004_0000, 4'hF);
    rdchk("locked pin2", 8'h08, 32'h8001);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("inBufOn mid reset", inBufOn, 32'h0);
    @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    rdchk("pin2 after reset", 8'h08, 32'h0);
    wr(8'h08, 32'h0000_0002, 4'hF);
    rdchk("pin2 unlocked", 8'h08, 32'h0002);
    completeRun();
  end
endmodule : test_pin_pad_config_global_write
